// *** include/fftg_pkg.sv ***
// Functional notes
// - registered invalid zeros gated stage-4 output
// - invalid effect seen after stage-5 latency
// - pulsar gating applied at stage-5 outputs
// - exponent overflow drives open-drain flag low
// - six flags wire-ORed, registered, exported low
// - everything runs on one 32 MHz clock
// - read address equals next stage write address
// - stage 0 and 5 use external addresses
// - 2K transform completes in 512 cycles
// - rotator inputs evenly spaced in time
// - stage-4 crosses pipes 0/1 and 2/3
// - stage-5 crosses pipes 0/2 and 1/3
// - bit 25 set at stage 0/4 large
// - bit 6: size, bypass or array
// - bit 5: radix or polarization
// - both pins high: correlate, row AND col
// - transform modes decode angle/twiddle enables
// - load select gates memories versus processor
// - floating bus-enable pins read as one
// - enable paths purely combinational, no registers
// - row/col pins reused in transform mode
package fftg_pkg;
    // ==================================================
    // sizes and timing
    localparam int NPIPE = 4;
    localparam int NSTAGE = 6;
    localparam int OVF_PER_PIPE = 6;
    localparam int ADDR_W = 9;
    localparam int CLK_MHZ = 32;
    localparam int XFORM_CYCLES = 512;
    localparam logic [8:0] LAST_CYCLE = 9'h1ff;
    // ==================================================
    // control word field positions
    localparam int BIT_EDGE = 25;
    localparam int BIT_SIZE = 6;
    localparam int BIT_RADIX = 5;
    localparam int EDGE_STAGE_A = 0;
    localparam int EDGE_STAGE_B = 4;
    // ==================================================
    // bus modes
    typedef enum logic [4:0] {
        FFTG_CORRELATE = 5'h01,
        FFTG_QUIET = 5'h02,
        FFTG_TWID_LOAD = 5'h04,
        FFTG_ANGLE_LOAD = 5'h08,
        FFTG_ANGLE_OUT = 5'h10
    } fftg_mode_t;
endpackage

// *** rtl/fftg_top.sv ***
`timescale 1ns/1ps
module fftg_top #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // per-pipeline data into stage 4
    input wire logic [fftg_pkg::NPIPE*W-1:0] s4_data_in,
    // invalid and pulsar gate flags
    input wire logic [fftg_pkg::NPIPE-1:0] sample_invalid_in,
    input wire logic [fftg_pkg::NPIPE-1:0] pulsar_in,
    input wire logic s4_gate_enable_bit,
    input wire logic s5_gate_enable_bit,
    // exponent overflow events per processor
    input wire logic [fftg_pkg::NPIPE*6-1:0] exp_adjust_ovf,
    output logic [fftg_pkg::NPIPE*6-1:0] exponent_overflow_n_o,
    output logic [fftg_pkg::NPIPE*6-1:0] exponent_overflow_n_oe,
    output logic [fftg_pkg::NPIPE-1:0] pipe_overflow_n,
    // external address buses
    input wire logic [fftg_pkg::ADDR_W-1:0] ext_s0_addr,
    input wire logic [fftg_pkg::ADDR_W-1:0] ext_s5_addr,
    output logic [fftg_pkg::NSTAGE*fftg_pkg::ADDR_W-1:0] stage_addr,
    // transform configuration
    input wire logic large_mode,
    input wire logic two_k_mode,
    input wire logic radix4_mode,
    input wire logic bypass_mode,
    input wire logic polar_mode,
    input wire logic array_one,
    output logic [fftg_pkg::NSTAGE-1:0] large_transform_edge_stage,
    output logic [fftg_pkg::NSTAGE-1:0] size_two_k_select,
    output logic [fftg_pkg::NSTAGE-1:0] radix_select,
    output logic xform_done,
    output logic [1:0] rotator_slot,
    // gated pipeline outputs
    output logic [fftg_pkg::NPIPE*W-1:0] s5_data_out,
    // tri-state bus control
    input wire logic angle_pin_val,
    input wire logic angle_pin_driven,
    input wire logic twid_pin_val,
    input wire logic twid_pin_driven,
    input wire logic row_sel_n,
    input wire logic col_sel_n,
    input wire logic table_load_select,
    output logic result_bus_oe,
    output logic angle_bus_oe,
    output logic twiddle_bus_oe,
    output logic card_mem_oe,
    output logic auxiliary_output,
    output fftg_pkg::fftg_mode_t bus_mode
);
    import fftg_pkg::*;

    // ==================================================
    // reset release
    logic [1:0] rst_sync_q;
    logic rst_ok_n;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_ok_n = rst_sync_q[1];

    // ==================================================
    // flag capture and cycle state
    logic [NPIPE-1:0] inval_q, inval_d, pulsar_q, pulsar_d;
    logic [NPIPE-1:0] povf_q, povf_d;
    logic [NPIPE*6-1:0] oe_q, oe_d;
    logic [8:0] cyc_q, cyc_d;
    logic done_q, done_d, phase_q, phase_d;
    logic [1:0] slot_q, slot_d;

    always_comb begin
        inval_d = sample_invalid_in;
        pulsar_d = pulsar_in;
        oe_d = exp_adjust_ovf;
        for (int p = 0; p < NPIPE; p++) begin
            povf_d[p] = ~|oe_q[p*OVF_PER_PIPE +: OVF_PER_PIPE];
        end
        cyc_d = large_mode ? cyc_q + 9'h001 : 9'h000;
        done_d = large_mode && (cyc_q == LAST_CYCLE);
        phase_d = large_mode ? ~phase_q : 1'b0;
        slot_d = slot_q + 2'h1;
    end

    always_ff @(posedge ref_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            inval_q <= '0;
            pulsar_q <= '0;
            oe_q <= '0;
            povf_q <= '1;
            cyc_q <= 9'h000;
            done_q <= 1'b0;
            phase_q <= 1'b0;
            slot_q <= 2'h0;
        end else begin
            inval_q <= inval_d;
            pulsar_q <= pulsar_d;
            oe_q <= oe_d;
            povf_q <= povf_d;
            cyc_q <= cyc_d;
            done_q <= done_d;
            phase_q <= phase_d;
            slot_q <= slot_d;
        end
    end
    assign exponent_overflow_n_o = '0;
    assign exponent_overflow_n_oe = oe_q;
    assign pipe_overflow_n = povf_q;
    assign xform_done = done_q;
    assign rotator_slot = slot_q;

    // ==================================================
    // stage 4 / stage 5 data path
    logic [NPIPE*W-1:0] s4_q, s4_d, s5_q, s5_d;
    always_comb begin
        s4_d = '0;
        s5_d = '0;
        for (int p = 0; p < NPIPE; p++) begin
            // partner pipe for 1K cross: 0<->1, 2<->3
            s4_d[p*W +: W] = (large_mode && phase_q)
                ? s4_data_in[(p^1)*W +: W]
                : s4_data_in[p*W +: W];
            if (s4_gate_enable_bit && inval_q[p]) begin
                s4_d[p*W +: W] = '0;
            end
            // partner pipe for 2K cross: 0<->2, 1<->3
            s5_d[p*W +: W] = (two_k_mode && phase_q)
                ? s4_q[(p^2)*W +: W]
                : s4_q[p*W +: W];
            if (s5_gate_enable_bit && pulsar_q[p]) begin
                s5_d[p*W +: W] = '0;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            s4_q <= '0;
            s5_q <= '0;
        end else begin
            s4_q <= s4_d;
            s5_q <= s5_d;
        end
    end
    assign s5_data_out = s5_q;

    // ==================================================
    // address routing
    logic [NSTAGE*ADDR_W-1:0] addr_q, addr_d;
    always_comb begin
        addr_d = addr_q;
        addr_d[0 +: ADDR_W] = ext_s0_addr;
        for (int s = 1; s < NSTAGE - 1; s++) begin
            addr_d[s*ADDR_W +: ADDR_W] =
                addr_q[(s-1)*ADDR_W +: ADDR_W];
        end
        addr_d[(NSTAGE-1)*ADDR_W +: ADDR_W] = ext_s5_addr;
    end
    always_ff @(posedge ref_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            addr_q <= '0;
        end else begin
            addr_q <= addr_d;
        end
    end
    assign stage_addr = addr_q;

    // ==================================================
    // per-stage control bits
    logic pin_a, pin_t, correlate;
    logic [NSTAGE-1:0] edge_q, edge_d, size_q, size_d, rdx_q, rdx_d;
    always_comb begin
        for (int s = 0; s < NSTAGE; s++) begin
            edge_d[s] = large_mode && !correlate &&
                (s == EDGE_STAGE_A || s == EDGE_STAGE_B);
            if (correlate) begin
                size_d[s] = polar_mode && array_one;
                rdx_d[s] = polar_mode;
            end else begin
                size_d[s] = radix4_mode ? bypass_mode
                    : two_k_mode;
                rdx_d[s] = radix4_mode;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            edge_q <= '0;
            size_q <= '0;
            rdx_q <= '0;
        end else begin
            edge_q <= edge_d;
            size_q <= size_d;
            rdx_q <= rdx_d;
        end
    end
    assign large_transform_edge_stage = edge_q;
    assign size_two_k_select = size_q;
    assign radix_select = rdx_q;

    // ==================================================
    // bus enable decode, no registers on purpose
    assign pin_a = angle_pin_driven ? angle_pin_val : 1'b1;
    assign pin_t = twid_pin_driven ? twid_pin_val : 1'b1;
    assign correlate = pin_a && pin_t;
    always_comb begin
        bus_mode = FFTG_QUIET;
        result_bus_oe = 1'b1;
        angle_bus_oe = 1'b0;
        twiddle_bus_oe = 1'b0;
        auxiliary_output = 1'b0;
        card_mem_oe = !table_load_select;
        if (correlate) begin
            bus_mode = FFTG_CORRELATE;
            result_bus_oe = !row_sel_n && !col_sel_n;
        end else begin
            auxiliary_output = !row_sel_n || !col_sel_n;
            // pins 0,0 drive neither bus, whatever the load select
            if (pin_a) begin
                bus_mode = table_load_select ? FFTG_ANGLE_LOAD
                    : FFTG_ANGLE_OUT;
                angle_bus_oe = 1'b1;
            end else if (pin_t) begin
                bus_mode = FFTG_TWID_LOAD;
                twiddle_bus_oe = table_load_select;
            end
        end
    end

    // ==================================================
    // checks
    sequence s_invalid_held;
        (s4_gate_enable_bit && sample_invalid_in[0])
        ##1 s4_gate_enable_bit;
    endsequence
    property p_invalid_zero;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        s_invalid_held |=> (s4_q[W-1:0] == '0);
    endproperty
    a_invalid_zero: assert property (p_invalid_zero)
        else $error("invalid did not zero stage 4");
    property p_stage5_delay;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        (!two_k_mode && !s5_gate_enable_bit)
        |=> (s5_q == $past(s4_q));
    endproperty
    a_stage5_delay: assert property (p_stage5_delay)
        else $error("stage 5 latency wrong");
    property p_pulsar_zero;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        (s5_gate_enable_bit && pulsar_q[1])
        |=> (s5_q[2*W-1:W] == '0);
    endproperty
    a_pulsar_zero: assert property (p_pulsar_zero)
        else $error("pulsar gate missed");
    property p_ovf_flag;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        exp_adjust_ovf[0] |=> exponent_overflow_n_oe[0]
        ##1 !pipe_overflow_n[0];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("overflow not exported");
    property p_addr_chain;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        1'b1 |=> (addr_q[2*ADDR_W-1:ADDR_W] ==
                  $past(addr_q[ADDR_W-1:0]));
    endproperty
    a_addr_chain: assert property (p_addr_chain)
        else $error("address chain broken");
    sequence s_count_up;
        large_mode && cyc_q == 9'h1fe ##1 large_mode;
    endsequence
    property p_done;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        s_count_up |=> xform_done;
    endproperty
    a_done: assert property (p_done)
        else $error("2K done not at 512");
    property p_edge_bit;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        1'b1 |=> !large_transform_edge_stage[1] &&
                 !large_transform_edge_stage[5];
    endproperty
    a_edge_bit: assert property (p_edge_bit)
        else $error("bit 25 set on wrong stage");
    property p_corr_oe;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        correlate |-> !angle_bus_oe && !twiddle_bus_oe &&
            (result_bus_oe == (!row_sel_n && !col_sel_n));
    endproperty
    a_corr_oe: assert property (p_corr_oe)
        else $error("correlate bus enables wrong");
    property p_xform_oe;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        !correlate |-> result_bus_oe &&
            (card_mem_oe == !table_load_select);
    endproperty
    a_xform_oe: assert property (p_xform_oe)
        else $error("transform bus enables wrong");
    property p_slot_step;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        rst_ok_n |=> (rotator_slot == $past(rotator_slot) + 2'h1);
    endproperty
    a_slot_step: assert property (p_slot_step)
        else $error("rotator slot did not step");
    property p_cross_1k;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        (large_mode && phase_q && !(s4_gate_enable_bit && inval_q[0]))
        |=> (s4_q[W-1:0] == $past(s4_data_in[2*W-1:W]));
    endproperty
    a_cross_1k: assert property (p_cross_1k)
        else $error("1K cross routing wrong");
    property p_cross_2k;
        @(posedge ref_clk) disable iff (!rst_ok_n)
        (two_k_mode && phase_q && !(s5_gate_enable_bit && pulsar_q[0]))
        |=> (s5_q[W-1:0] == $past(s4_q[3*W-1:2*W]));
    endproperty
    a_cross_2k: assert property (p_cross_2k)
        else $error("2K cross routing wrong");
endmodule // fftg_top

// *** test/fftg_ctl_model.sv ***
`timescale 1ns/1ps
module fftg_ctl_model #(
    parameter int FRAME = 16
) (
    // clock
    input wire logic ref_clk,
    // per-pipe invalid request and held flag
    input wire logic [3:0] inv_req,
    output logic [3:0] sample_invalid
);
    // ==================================================
    // frame hold
    int left [4] = '{default: 0};
    logic [3:0] seen = 4'h0;
    logic [3:0] inv_q = 4'h0;
    assign sample_invalid = inv_q;
    always @(posedge ref_clk) begin
        seen <= inv_req;
    end
    // output moves off the sampling edge, held a whole frame
    always @(negedge ref_clk) begin
        for (int p = 0; p < 4; p++) begin
            if (seen[p]) left[p] = FRAME;
            else if (left[p] > 0) left[p]--;
            inv_q[p] = left[p] > 0;
        end
    end
endmodule // fftg_ctl_model

// *** test/fftg_top_tb.sv ***
`timescale 1ns/1ps
module fftg_top_tb;
    import fftg_pkg::*;
    typedef struct {int due; int sel; logic [63:0] v;} fftg_note_t;
    // ==================================================
    // signals
    logic ref_clk = 0;
    logic rst_n = 0;
    logic [63:0] s4_data_in = 0, s5_data_out;
    logic [3:0] inv_req = 0, pulsar_in = 0, sample_invalid_in, pipe_ovf_n;
    logic s4_en = 0, s5_en = 0, xform_done, res_oe, ang_oe, twid_oe;
    logic mem_oe, aux_out;
    logic [6:0] straps [4] = '{7'h3f, 7'h6f, 7'h6e, 7'h2e};
    logic [23:0] exp_adjust_ovf = 0, ovf_oe;
    logic [8:0] ext_s0_addr = 0, ext_s5_addr = 0;
    logic [53:0] stage_addr;
    logic [5:0] cfg = 0, edge_b, size_b, radix_b;
    logic [6:0] bus_in = 7'h00;
    fftg_mode_t bus_mode;
    fftg_note_t notes[$];
    fftg_note_t n;
    int cyc = 0, num_errors = 0, compares = 0;
    fftg_top #(.W(16)) fftg_top_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .s4_data_in(s4_data_in),
        .sample_invalid_in(sample_invalid_in), .pulsar_in(pulsar_in),
        .s4_gate_enable_bit(s4_en), .s5_gate_enable_bit(s5_en),
        .exp_adjust_ovf(exp_adjust_ovf), .exponent_overflow_n_o(),
        .exponent_overflow_n_oe(ovf_oe), .pipe_overflow_n(pipe_ovf_n),
        .ext_s0_addr(ext_s0_addr), .ext_s5_addr(ext_s5_addr),
        .stage_addr(stage_addr), .large_mode(cfg[5]), .two_k_mode(cfg[4]),
        .radix4_mode(cfg[3]), .bypass_mode(cfg[2]), .polar_mode(cfg[1]),
        .array_one(cfg[0]), .large_transform_edge_stage(edge_b),
        .size_two_k_select(size_b), .radix_select(radix_b),
        .xform_done(xform_done), .rotator_slot(), .s5_data_out(s5_data_out),
        .angle_pin_val(bus_in[6]), .angle_pin_driven(bus_in[5]),
        .twid_pin_val(bus_in[4]), .twid_pin_driven(bus_in[3]),
        .row_sel_n(bus_in[2]), .col_sel_n(bus_in[1]),
        .table_load_select(bus_in[0]), .result_bus_oe(res_oe),
        .angle_bus_oe(ang_oe), .twiddle_bus_oe(twid_oe),
        .card_mem_oe(mem_oe), .auxiliary_output(aux_out),
        .bus_mode(bus_mode));
    fftg_ctl_model #(.FRAME(16)) fftg_ctl_model_i (.ref_clk(ref_clk),
        .inv_req(inv_req), .sample_invalid(sample_invalid_in));
    // ==================================================
    // clock, hang guard, scoreboard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    function automatic logic [63:0] pick(int sel);
        case (sel)
            0: pick = {48'h0, s5_data_out[15:0]};
            1: pick = {40'h0, ovf_oe};
            2: pick = {60'h0, pipe_ovf_n};
            3: pick = {54'h0, aux_out, bus_mode, res_oe, ang_oe, twid_oe,
                mem_oe};
            4: pick = {46'h0, edge_b, size_b, radix_b};
            5: pick = {46'h0, stage_addr[53:45], stage_addr[8:0]};
            default: pick = {63'h0, xform_done};
        endcase
    endfunction
    always @(negedge ref_clk) begin
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            n = notes.pop_front();
            compares++;
            if (pick(n.sel) !== n.v) begin
                $display("BAD t=%0t got %h exp %h", $time, pick(n.sel), n.v);
                num_errors++;
            end
        end
    end
    task automatic note(int k, int sel, logic [63:0] v);
        notes.push_back('{cyc + k, sel, v});
    endtask
    // undriven pin reads one
    function automatic logic [63:0] exp_bus(logic [6:0] b);
        logic a, t, l;
        fftg_mode_t m;
        a = b[5] ? b[6] : 1'b1;
        t = b[3] ? b[4] : 1'b1;
        l = b[0];
        if (a & t) m = FFTG_CORRELATE;
        else if (a) m = l ? FFTG_ANGLE_LOAD : FFTG_ANGLE_OUT;
        else if (t) m = FFTG_TWID_LOAD;
        else m = FFTG_QUIET;
        exp_bus = {54'h0, ~(a & t) & (~b[2] | ~b[1]), m,
            (a & t) ? ~b[2] & ~b[1] : 1'b1, a & ~t, ~a & t & l, ~l};
    endfunction
    function automatic logic [3:0] flags(logic [23:0] o);
        for (int p = 0; p < 4; p++) flags[p] = ~|o[p*6+:6];
    endfunction
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==================================================
    // scenarios
    initial begin
        void'($urandom(30752));
        note(1, 3, exp_bus(bus_in));
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        for (int i = 0; i < 32; i++) begin
            bus_in = 7'($urandom());
            note(1, 3, exp_bus(bus_in));
            repeat (2) @(negedge ref_clk);
        end
        foreach (straps[j]) begin
            bus_in = straps[j];
            note(1, 3, exp_bus(bus_in));
            repeat (2) @(negedge ref_clk);
        end
        for (int i = 0; i < 16; i++) begin
            bus_in = i[0] ? 7'h00 : 7'h6e;
            cfg = 6'($urandom());
            ext_s0_addr = 9'($urandom());
            ext_s5_addr = 9'($urandom());
            note(1, 4, {46'h0, (cfg[5] & ~i[0]) ? 6'h11 : 6'h0,
                {6{i[0] ? cfg[1] & cfg[0] : (cfg[3] ? cfg[2] : cfg[4])}},
                {6{i[0] ? cfg[1] : cfg[3]}}});
            note(1, 5, {46'h0, ext_s5_addr, ext_s0_addr});
            repeat (2) @(negedge ref_clk);
        end
        for (int i = 0; i < 12; i++) begin
            exp_adjust_ovf = 24'($urandom() & $urandom() & $urandom());
            note(1, 1, {40'h0, exp_adjust_ovf});
            note(2, 2, {60'h0, flags(exp_adjust_ovf)});
            repeat (3) @(negedge ref_clk);
        end
        cfg = 6'h0;
        s4_data_in = {$urandom(), $urandom()};
        s4_en = 1'b1;
        s5_en = 1'b1;
        repeat (6) @(negedge ref_clk);
        inv_req = 4'h1;
        @(negedge ref_clk);
        inv_req = 4'h0;
        note(2, 0, {48'h0, s4_data_in[15:0]});
        note(3, 0, 64'h0);
        repeat (20) @(negedge ref_clk);
        pulsar_in = 4'h3;
        note(1, 0, {48'h0, s4_data_in[15:0]});
        note(2, 0, 64'h0);
        repeat (3) @(negedge ref_clk);
        pulsar_in = 4'h0;
        cfg = 6'h30;
        for (int i = 0; i < 600 && xform_done !== 1'b1; i++)
            @(negedge ref_clk);
        note(511, 6, 64'h0);
        note(512, 6, 64'h1);
        repeat (514) @(negedge ref_clk);
        tally_and_finish();
    end
endmodule // fftg_top_tb
